// File: rtl/ppp_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_top (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] data_in,
   input wire logic load_select_hi_in,
   input wire logic load_select_lo_in,
   input wire logic byte_select_in,
   input wire logic load_strobe_in,
   input wire logic page_latch_in,
   input wire logic write_n_in,
   input wire logic [13:0] rd_addr_in,
   output logic ready_busy_n_out,
   output logic [15:0] flash_rd_out,
   output logic [7:0] eeprom_rd_out,
   output logic write_active_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {
      PPP_IDLE,
      PPP_FLASH,
      PPP_EEPROM
   } ppp_mode_t;

   typedef struct packed {
      ppp_mode_t mode;
      logic [7:0] cmd;
      logic [7:0] addr_lo;
      logic [7:0] addr_hi;
      logic [7:0] data_lo;
      logic [7:0] data_hi;
      logic [15:0] tmr;
      logic [13:0] page_base;
      logic ready;
      logic busy_wr;
      logic [15:0] frd;
      logic [7:0] erd;
   } ppp_state_t;

   ppp_state_t st_reg;
   ppp_state_t st_next;

   // memories and the eeprom page buffer are arrays with no reset, like real cells; the flash buffer resets to erased
   logic [15:0] fl_buf [ppp_pkg::FL_WORDS];
   logic [7:0] ee_buf [ppp_pkg::EE_BYTES];
   logic [15:0] fl_mem [ppp_pkg::FL_WORDS * ppp_pkg::FL_PAGES];
   logic [7:0] ee_mem [ppp_pkg::EE_BYTES * ppp_pkg::EE_PAGES];

   logic ld_pulse;
   logic pl_pulse;
   logic wr_pulse;
   logic [1:0] sel;
   logic commit;
   logic [ppp_pkg::FL_WORD_BITS-1:0] fl_word;
   logic [ppp_pkg::EE_BYTE_BITS-1:0] ee_byte;
   logic [13:0] fl_page_base;
   logic [13:0] ee_page_base;

   // ----------------------------------------
   // strobe edges
   // ----------------------------------------
   ppp_edge u_ld (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .sig_in(load_strobe_in),
      .rise_out(ld_pulse),
      .fall_out()
   );
   ppp_edge u_pl (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .sig_in(page_latch_in),
      .rise_out(pl_pulse),
      .fall_out()
   );
   ppp_edge u_wr (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .sig_in(write_n_in),
      .rise_out(),
      .fall_out(wr_pulse)
   );

   assign sel = {load_select_hi_in, load_select_lo_in};
   assign fl_word = st_reg.addr_lo[ppp_pkg::FL_WORD_BITS-1:0];
   assign ee_byte = st_reg.addr_lo[ppp_pkg::EE_BYTE_BITS-1:0];
   // page index spans bit 0 of the address high byte plus spare upper bits of the low byte
   assign fl_page_base = {5'h00, st_reg.addr_hi[0], st_reg.addr_lo[7:ppp_pkg::FL_WORD_BITS],
                          {ppp_pkg::FL_WORD_BITS{1'b0}}};
   assign ee_page_base = {5'h00, st_reg.addr_hi[0], st_reg.addr_lo[7:ppp_pkg::EE_BYTE_BITS],
                          {ppp_pkg::EE_BYTE_BITS{1'b0}}};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      commit = 1'b0;
      if (ld_pulse && st_reg.ready) begin
         case (sel)
            ppp_pkg::SEL_CMD: begin
               st_next.cmd = data_in;
               if (data_in == ppp_pkg::CMD_NOP) begin
                  st_next.mode = PPP_IDLE;
               end else if (data_in == ppp_pkg::CMD_WR_FLASH) begin
                  st_next.mode = PPP_FLASH;
               end else if (data_in == ppp_pkg::CMD_WR_EEPROM) begin
                  st_next.mode = PPP_EEPROM;
               end else begin
                  st_next.mode = PPP_IDLE;
               end
            end
            ppp_pkg::SEL_ADDR: begin
               if (byte_select_in) begin
                  st_next.addr_hi = data_in;
               end else begin
                  st_next.addr_lo = data_in;
               end
            end
            ppp_pkg::SEL_DATA: begin
               if (byte_select_in) begin
                  st_next.data_hi = data_in;
               end else begin
                  st_next.data_lo = data_in;
               end
            end
            default: begin
            end
         endcase
      end
      // a write pulse is honoured only while ready, busy blocks overlap
      if (wr_pulse && !byte_select_in && st_reg.ready) begin
         case (st_reg.mode)
            PPP_FLASH: begin
               st_next.ready = 1'b0;
               st_next.busy_wr = 1'b1;
               st_next.tmr = 16'(ppp_pkg::FL_WRITE_CYC);
               st_next.page_base = fl_page_base;
            end
            PPP_EEPROM: begin
               st_next.ready = 1'b0;
               st_next.busy_wr = 1'b1;
               st_next.tmr = 16'(ppp_pkg::EE_WRITE_CYC);
               st_next.page_base = ee_page_base;
            end
            default: begin
            end
         endcase
      end
      if (st_reg.busy_wr) begin
         if (st_reg.tmr == 16'h0001) begin
            st_next.busy_wr = 1'b0;
            st_next.ready = 1'b1;
            commit = 1'b1;
         end else begin
            st_next.tmr = st_reg.tmr - 16'h0001;
         end
      end
      st_next.frd = fl_mem[rd_addr_in[12:0]];
      st_next.erd = ee_mem[rd_addr_in[8:0]];
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= '0;
         st_reg.mode <= PPP_IDLE;
         st_reg.ready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // page buffers and arrays
   // ----------------------------------------
   // one process per array, so each memory has a single writer
   always_ff @(posedge clk_in) begin
      if (commit && st_reg.mode == PPP_FLASH) begin
         for (int k = 0; k < ppp_pkg::FL_WORDS; k++) begin
            fl_mem[st_reg.page_base[12:0] + 13'(k)] <= fl_buf[k];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (commit && st_reg.mode == PPP_EEPROM) begin
         for (int k = 0; k < ppp_pkg::EE_BYTES; k++) begin
            ee_mem[st_reg.page_base[8:0] + 9'(k)] <= ee_buf[k];
         end
      end
   end

   generate
      for (genvar i = 0; i < ppp_pkg::FL_WORDS; i++) begin : g_fl
         // buffer starts erased, so words never latched program as erased
         always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               fl_buf[i] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
            end else if (pl_pulse && byte_select_in && st_reg.mode == PPP_FLASH
                && fl_word == ppp_pkg::FL_WORD_BITS'(i)) begin
               fl_buf[i] <= {st_reg.data_hi, st_reg.data_lo};
            end else if (commit && st_reg.mode == PPP_FLASH) begin
               fl_buf[i] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
            end
         end
      end
      for (genvar j = 0; j < ppp_pkg::EE_BYTES; j++) begin : g_ee
         always_ff @(posedge clk_in) begin
            // eeprom latch takes one byte per address, any byte_select
            if (pl_pulse && st_reg.mode == PPP_EEPROM
                && ee_byte == ppp_pkg::EE_BYTE_BITS'(j)) begin
               ee_buf[j] <= st_reg.data_lo;
            end
         end
      end
   endgenerate

   assign ready_busy_n_out = st_reg.ready;
   assign write_active_out = st_reg.busy_wr;
   assign flash_rd_out = st_reg.frd;
   assign eeprom_rd_out = st_reg.erd;
endmodule // ppp_top
`default_nettype wire

// File: rtl/ppp_pkg.sv
package ppp_pkg;
   // ----------------------------------------
   // load-select codes
   // ----------------------------------------
   localparam logic [1:0] SEL_ADDR = 2'h0;
   localparam logic [1:0] SEL_DATA = 2'h1;
   localparam logic [1:0] SEL_CMD = 2'h2;
   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
   // ----------------------------------------
   // page geometry
   // ----------------------------------------
   localparam int FL_WORD_BITS = 6;
   localparam int FL_PAGES = 128;
   localparam int EE_BYTE_BITS = 2;
   localparam int EE_PAGES = 128;
   localparam int FL_WORDS = 1 << FL_WORD_BITS;
   localparam int EE_BYTES = 1 << EE_BYTE_BITS;
   // ----------------------------------------
   // write times
   // ----------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int FL_WRITE_US = 5;
   localparam int EE_WRITE_US = 10;
   localparam int FL_WRITE_CYC = FL_WRITE_US * CLK_MHZ;
   localparam int EE_WRITE_CYC = EE_WRITE_US * CLK_MHZ;
   localparam int TIMER_W = 16;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

// File: rtl/ppp_edge.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// rising and falling edge detector
// ----------------------------------------
module ppp_edge (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic sig_in,
   output logic rise_out,
   output logic fall_out
);
   typedef struct packed {
      logic last;
   } ppp_edge_state_t;
   ppp_edge_state_t st_reg;
   ppp_edge_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.last = sig_in;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise_out = sig_in & ~st_reg.last;
   assign fall_out = ~sig_in & st_reg.last;
endmodule // ppp_edge
`default_nettype wire

// File: testbench/ppp_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// busy-line checks
// ---
module ppp_top_monitor (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic write_n_in,
   input wire logic ready_busy_n_out,
   input wire logic write_active_out
);
   localparam int FL = ppp_pkg::FL_WRITE_CYC;
   localparam int EE = ppp_pkg::EE_WRITE_CYC;
   logic [15:0] cnt_reg;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // busy length kept as a count, too long for a repetition
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) cnt_reg <= 16'h0;
      else cnt_reg <= ready_busy_n_out ? 16'h0 : cnt_reg + 16'h1;
   end
   a_busy_start: assert property ($fell(ready_busy_n_out) |->
      !$past(write_n_in) || !$past(write_n_in, 2)) else $error("busy without write");
   a_busy_hold: assert property ($fell(ready_busy_n_out) |->
      !ready_busy_n_out [*8]) else $error("busy too short");
   a_busy_len: assert property ($rose(ready_busy_n_out) |->
      cnt_reg == FL || cnt_reg == EE) else $error("busy length wrong");
   a_busy_max: assert property (cnt_reg <= EE)
      else $error("busy overrun");
   a_idle_keep: assert property (ready_busy_n_out && write_n_in && $past(write_n_in)
      |=> ready_busy_n_out) else $error("busy with no cause");
   a_active_busy: assert property (write_active_out |-> !ready_busy_n_out)
      else $error("active while ready");
   a_active_set: assert property (!ready_busy_n_out && !$past(ready_busy_n_out)
      |-> write_active_out) else $error("busy but not active");
   a_active_end: assert property ($rose(ready_busy_n_out) |-> !write_active_out)
      else $error("active after ready");
   cover property ($rose(ready_busy_n_out) && cnt_reg == FL);
   cover property ($rose(ready_busy_n_out) && cnt_reg == EE);
   cover property ($fell(ready_busy_n_out));
endmodule // ppp_top_monitor
bind ppp_top ppp_top_monitor u_mon (.clk_in, .rstn_in, .write_n_in, .ready_busy_n_out,
   .write_active_out);
`default_nettype wire

// File: testbench/ppp_prog.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// programmer model
// ---
module ppp_prog (
   input wire logic clk_in,
   input wire logic rdy_in,
   output logic [7:0] d_out,
   output logic hi_out,
   output logic lo_out,
   output logic bs_out,
   output logic stb_out,
   output logic pl_out,
   output logic wr_n_out
);
   initial begin
      {d_out, hi_out, lo_out, bs_out, stb_out, pl_out} = '0;
      wr_n_out = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // lines held over the pulse; the bus is then released, shown inverted
   task automatic ld(input logic [1:0] s, input logic b, input logic [7:0] d);
      {hi_out, lo_out} = s;
      bs_out = b;
      d_out = d;
      stb_out = 1'b1;
      tick(2);
      stb_out = 1'b0;
      tick(1);
      d_out = ~d;
      tick(1);
   endtask
   task automatic latch;
      bs_out = 1'b1;
      pl_out = 1'b1;
      tick(2);
      pl_out = 1'b0;
      tick(2);
   endtask
   task automatic wr;
      bs_out = 1'b0;
      wr_n_out = 1'b0;
      tick(2);
      wr_n_out = 1'b1;
      tick(2);
   endtask
   task automatic wait_rdy;
      repeat (1000) if (rdy_in !== 1'b1) tick(1);
   endtask
endmodule // ppp_prog
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [13:0] ra = 14'h0;
   logic [7:0] d;
   logic hi, lo, bs, stb, pl, wr_n, rdy, act;
   logic [15:0] f_rd;
   logic [7:0] e_rd;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int low_n = 0;
   logic [15:0] fbuf [64];
   logic [7:0] ebuf [4];
   always #12.5 clk_in = ~clk_in;
   // ---
   // busy counter and hang guard
   // ---
   always @(posedge clk_in) begin
      cyc++;
      if (rdy === 1'b0) low_n++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   ppp_top u_ppp_top (.clk_in(clk_in), .rstn_in(rstn_in), .data_in(d),
      .load_select_hi_in(hi), .load_select_lo_in(lo), .byte_select_in(bs),
      .load_strobe_in(stb), .page_latch_in(pl), .write_n_in(wr_n), .rd_addr_in(ra),
      .ready_busy_n_out(rdy), .flash_rd_out(f_rd), .eeprom_rd_out(e_rd),
      .write_active_out(act));
   ppp_prog u_ppp_prog (.clk_in(clk_in), .rdy_in(rdy), .d_out(d), .hi_out(hi),
      .lo_out(lo), .bs_out(bs), .stb_out(stb), .pl_out(pl), .wr_n_out(wr_n));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [13:0] a, input logic [15:0] e, input logic f);
      ra = a;
      repeat (2) @(posedge clk_in);
      #1;
      chk(f ? "flash" : "eeprom", e, f ? f_rd : {8'h0, e_rd});
   endtask
   task automatic prog(input int n);
      low_n = 0;
      u_ppp_prog.wr();
      chk("active", 16'(n != 0), {15'h0, act});
      u_ppp_prog.wait_rdy();
      chk("active end", 16'h0, {15'h0, act});
      chk("busy", 16'(n), 16'(low_n));
   endtask
   task automatic flash_page(input logic [1:0] pg, input logic cmd);
      logic [7:0] a;
      logic [15:0] w;
      for (int i = 0; i < 64; i++) fbuf[i] = 16'hffff;
      if (cmd) u_ppp_prog.ld(2'h2, 1'b0, ppp_pkg::CMD_WR_FLASH);
      repeat (6) begin
         a = {pg, 6'($urandom)};
         w = 16'($urandom);
         fbuf[a[5:0]] = w;
         u_ppp_prog.ld(2'h0, 1'b0, a);
         u_ppp_prog.ld(2'h1, 1'b0, w[7:0]);
         u_ppp_prog.ld(2'h1, 1'b1, w[15:8]);
         u_ppp_prog.latch();
      end
      u_ppp_prog.ld(2'h0, 1'b1, 8'h0);
      prog(ppp_pkg::FL_WRITE_CYC);
      for (int i = 0; i < 64; i++) rd({6'h0, pg, 6'(i)}, fbuf[i], 1'b1);
   endtask
   task automatic ee_page;
      logic [7:0] h = 8'($urandom % 2);
      logic [7:0] l = {6'($urandom), 2'h0};
      u_ppp_prog.ld(2'h2, 1'b0, ppp_pkg::CMD_WR_EEPROM);
      u_ppp_prog.ld(2'h0, 1'b1, h);
      for (int i = 0; i < 4; i++) begin
         ebuf[i] = 8'($urandom);
         u_ppp_prog.ld(2'h0, 1'b0, l + 8'(i));
         u_ppp_prog.ld(2'h1, 1'b0, ebuf[i]);
         u_ppp_prog.latch();
      end
      prog(ppp_pkg::EE_WRITE_CYC);
      for (int i = 0; i < 4; i++) rd({5'h0, h[0], l + 8'(i)}, {8'h0, ebuf[i]}, 1'b0);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(69));
      repeat (8) @(posedge clk_in);
      #1;
      rstn_in = 1'b1;
      u_ppp_prog.tick(1);
      flash_page(2'($urandom), 1'b1);
      $display("flash page test done");
      flash_page(2'($urandom), 1'b0);
      $display("kept command test done");
      u_ppp_prog.ld(2'h2, 1'b0, ppp_pkg::CMD_NOP);
      prog(0);
      $display("no-op test done");
      ee_page();
      $display("eeprom page test done");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
